// ==== src/rms_defs.svh ====
// constants for the radio modem synchronous data port
// assumes a single core clock at RMS_CLK_HZ; included by bare name
`ifndef RMS_DEFS_SVH
`define RMS_DEFS_SVH

// core clock rate in hertz
`define RMS_CLK_HZ        100000000

// wake-up bound after shutdown release, in milliseconds
`define RMS_WAKE_MS       75
// sync and register latency come off the count so the time from the
// pin to ready stays inside the bound
`define RMS_WAKE_LAT      8
`define RMS_WAKE_CYC      (`RMS_WAKE_MS * (`RMS_CLK_HZ / 1000) - `RMS_WAKE_LAT)

// supported over-the-air payload rates, bits per second
`define RMS_RATE_4800     4800
`define RMS_RATE_8000     8000
`define RMS_RATE_9600     9600
`define RMS_RATE_16000    16000
`define RMS_RATE_19200    19200

// bit periods in core clock cycles, derived from the rates
`define RMS_BIT_CYC_4800  (`RMS_CLK_HZ / `RMS_RATE_4800)
`define RMS_BIT_CYC_8000  (`RMS_CLK_HZ / `RMS_RATE_8000)
`define RMS_BIT_CYC_9600  (`RMS_CLK_HZ / `RMS_RATE_9600)
`define RMS_BIT_CYC_16000 (`RMS_CLK_HZ / `RMS_RATE_16000)
`define RMS_BIT_CYC_19200 (`RMS_CLK_HZ / `RMS_RATE_19200)

// rate select codes
`define RMS_SEL_4800      3'h0
`define RMS_SEL_8000      3'h1
`define RMS_SEL_9600      3'h2
`define RMS_SEL_16000     3'h3
`define RMS_SEL_19200     3'h4

// widths
`define RMS_PER_W         16
`define RMS_WAKE_W        24
`define RMS_LVL_W         8

`endif

// ==== src/rms_pkg.sv ====
// types shared by the radio modem data port
// assumes rms_defs.svh is on the include path
`include "rms_defs.svh"

package rms_pkg;

   // operating state, one-hot
   typedef enum logic [4:0] {
      RMS_ST_OFF   = 5'h01,
      RMS_ST_WAKE  = 5'h02,
      RMS_ST_SETUP = 5'h04,
      RMS_ST_RX    = 5'h08,
      RMS_ST_TX    = 5'h10
   } rms_state_t;

   // host-side control pins, all asynchronous to core_clk
   typedef struct packed {
      logic shutdown_b;
      logic setup_b;
      logic key_req;
      logic tx_data;
   } rms_pins_t;

   // static configuration from the setup processor
   typedef struct packed {
      logic [2:0]            rate_sel;
      logic                  clk_rx_timing;
      logic [`RMS_LVL_W-1:0] carrier_threshold_setting;
   } rms_cfg_t;

   // host-side outputs
   typedef struct packed {
      logic rx_data;
      logic rx_clk;
      logic tx_clk;
      logic lock;
      logic carrier_present_out;
   } rms_host_out_t;

endpackage : rms_pkg

// ==== src/rms_bit_timer.sv ====
// bit period timer: counts one bit period and marks start, centre
// assumes period is at least 2 and comes from core_clk logic
`timescale 1ns/10ps
`include "rms_defs.svh"

module rms_bit_timer (
   input  wire logic                   core_clk,
   input  wire logic                   rst_b,
   input  wire logic                   run,
   input  wire logic                   restart,
   input  wire logic [`RMS_PER_W-1:0]  period,
   output logic                        bit_start,
   output logic                        bit_mid,
   output logic                        first_half
);
   import rms_pkg::*;

   logic [`RMS_PER_W-1:0] cnt_r;
   logic [`RMS_PER_W-1:0] cnt_nxt;
   logic [`RMS_PER_W-1:0] half;

   // >= guards a rate change that shortens the period mid-bit
   always_comb begin
      half = period >> 1;
      if (!run || restart) begin
         cnt_nxt = '0;
      end else if (cnt_r >= period - `RMS_PER_W'(1)) begin
         cnt_nxt = '0;
      end else begin
         cnt_nxt = cnt_r + `RMS_PER_W'(1);
      end
      bit_start  = run && (cnt_r == '0);
      bit_mid    = run && (cnt_r == half);
      first_half = cnt_r < half;
   end

   // counter register
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

endmodule // rms_bit_timer

// ==== src/rms_data_port.sv ====
// host data port of a half-duplex radio modem, acting as the DCE
// assumes demodulator, synthesizer monitor and rssi run on core_clk,
// host pins and the raw synthesizer lock are asynchronous
`timescale 1ns/10ps
`include "rms_defs.svh"

module rms_data_port #(
   parameter int unsigned WAKE_CYC      = `RMS_WAKE_CYC,
   parameter int unsigned BIT_CYC_4800  = `RMS_BIT_CYC_4800,
   parameter int unsigned BIT_CYC_8000  = `RMS_BIT_CYC_8000,
   parameter int unsigned BIT_CYC_9600  = `RMS_BIT_CYC_9600,
   parameter int unsigned BIT_CYC_16000 = `RMS_BIT_CYC_16000,
   parameter int unsigned BIT_CYC_19200 = `RMS_BIT_CYC_19200
) (
   input  wire logic                   core_clk,
   input  wire logic                   rst_b,
   input  wire rms_pkg::rms_pins_t     host_pins,
   input  wire rms_pkg::rms_cfg_t      cfg,
   input  wire logic                   synth_lock_raw,
   input  wire logic [`RMS_LVL_W-1:0]  rssi_level,
   input  wire logic                   demod_bit,
   input  wire logic                   proc_cfg_data,
   output rms_pkg::rms_host_out_t      host_out,
   output logic                        mod_bit,
   output logic                        mod_bit_strobe,
   output logic                        proc_cfg_rx,
   output logic                        radio_enable,
   output logic                        port_ready
);
   import rms_pkg::*;

   // two-stage synchronisers for the asynchronous inputs
   rms_pins_t             pins_s1_r;
   rms_pins_t             pins_s1_nxt;
   rms_pins_t             pins_s2_r;
   rms_pins_t             pins_s2_nxt;
   logic                  lock_s1_r;
   logic                  lock_s1_nxt;
   logic                  lock_s2_r;
   logic                  lock_s2_nxt;

   // operating state and wake-up timer
   rms_state_t            state_r;
   rms_state_t            state_nxt;
   logic [`RMS_WAKE_W-1:0] wake_cnt_r;
   logic [`RMS_WAKE_W-1:0] wake_cnt_nxt;
   logic                  wake_done;

   // bit timing
   logic [`RMS_PER_W-1:0] bit_period;
   logic                  timer_run;
   logic                  timer_restart;
   logic                  bit_start;
   logic                  bit_mid;
   logic                  first_half;

   // registered outputs
   rms_host_out_t         out_r;
   rms_host_out_t         out_nxt;
   logic                  mod_bit_r;
   logic                  mod_bit_nxt;
   logic                  mod_strobe_r;
   logic                  mod_strobe_nxt;
   logic                  proc_rx_r;
   logic                  proc_rx_nxt;
   logic                  radio_en_r;
   logic                  radio_en_nxt;
   logic                  ready_r;
   logic                  ready_nxt;

   // rate code to bit period; unknown codes fall back to the slowest
   function automatic logic [`RMS_PER_W-1:0] rate_period(
      input logic [2:0] sel
   );
      logic [`RMS_PER_W-1:0] p;
      p = `RMS_PER_W'(BIT_CYC_4800);
      unique case (sel)
         `RMS_SEL_4800:  p = `RMS_PER_W'(BIT_CYC_4800);
         `RMS_SEL_8000:  p = `RMS_PER_W'(BIT_CYC_8000);
         `RMS_SEL_9600:  p = `RMS_PER_W'(BIT_CYC_9600);
         `RMS_SEL_16000: p = `RMS_PER_W'(BIT_CYC_16000);
         `RMS_SEL_19200: p = `RMS_PER_W'(BIT_CYC_19200);
         default:        p = `RMS_PER_W'(BIT_CYC_4800);
      endcase
      return p;
   endfunction

   // stage one is read only by stage two
   always_comb begin
      pins_s1_nxt = host_pins;
      pins_s2_nxt = pins_s1_r;
      lock_s1_nxt = synth_lock_raw;
      lock_s2_nxt = lock_s1_r;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pins_s1_r <= '0;
         pins_s2_r <= '0;
         lock_s1_r <= 1'b0;
         lock_s2_r <= 1'b0;
      end else begin
         pins_s1_r <= pins_s1_nxt;
         pins_s2_r <= pins_s2_nxt;
         lock_s1_r <= lock_s1_nxt;
         lock_s2_r <= lock_s2_nxt;
      end
   end

   // mode selection; shutdown overrides every other state
   always_comb begin
      state_nxt = state_r;
      if (!pins_s2_r.shutdown_b) begin
         state_nxt = RMS_ST_OFF;
      end else begin
         unique case (state_r)
            RMS_ST_OFF: begin
               state_nxt = RMS_ST_WAKE;
            end
            RMS_ST_WAKE: begin
               if (wake_done) begin
                  // setup select outranks the key request
                  if (!pins_s2_r.setup_b) begin
                     state_nxt = RMS_ST_SETUP;
                  end else if (pins_s2_r.key_req) begin
                     state_nxt = RMS_ST_TX;
                  end else begin
                     state_nxt = RMS_ST_RX;
                  end
               end
            end
            RMS_ST_SETUP: begin
               if (pins_s2_r.setup_b) begin
                  state_nxt = pins_s2_r.key_req ? RMS_ST_TX : RMS_ST_RX;
               end
            end
            RMS_ST_RX: begin
               if (!pins_s2_r.setup_b) begin
                  state_nxt = RMS_ST_SETUP;
               end else if (pins_s2_r.key_req) begin
                  state_nxt = RMS_ST_TX;
               end
            end
            RMS_ST_TX: begin
               if (!pins_s2_r.setup_b) begin
                  state_nxt = RMS_ST_SETUP;
               end else if (!pins_s2_r.key_req) begin
                  state_nxt = RMS_ST_RX;
               end
            end
         endcase
      end
   end

   // wake-up count runs only in the wake state
   always_comb begin
      wake_done    = (wake_cnt_r >= `RMS_WAKE_W'(WAKE_CYC - 1));
      wake_cnt_nxt = '0;
      if (state_r == RMS_ST_WAKE && !wake_done) begin
         wake_cnt_nxt = wake_cnt_r + `RMS_WAKE_W'(1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         state_r    <= RMS_ST_OFF;
         wake_cnt_r <= '0;
      end else begin
         state_r    <= state_nxt;
         wake_cnt_r <= wake_cnt_nxt;
      end
   end

   // the timer restarts on every mode change so bits begin clean
   always_comb begin
      bit_period    = rate_period(cfg.rate_sel);
      timer_run     = (state_r == RMS_ST_RX) || (state_r == RMS_ST_TX);
      timer_restart = (state_nxt != state_r);
   end

   rms_bit_timer u_bit_timer (
      .core_clk   (core_clk),
      .rst_b      (rst_b),
      .run        (timer_run),
      .restart    (timer_restart),
      .period     (bit_period),
      .bit_start  (bit_start),
      .bit_mid    (bit_mid),
      .first_half (first_half)
   );

   // host-side clocks, data and indicators
   always_comb begin
      out_nxt                     = out_r;
      out_nxt.lock                = 1'b0;
      out_nxt.carrier_present_out = 1'b1;
      unique case (state_r)
         RMS_ST_OFF, RMS_ST_WAKE: begin
            out_nxt.rx_data = 1'b0;
            out_nxt.rx_clk  = 1'b0;
            out_nxt.tx_clk  = 1'b0;
         end
         RMS_ST_SETUP: begin
            out_nxt.rx_data = proc_cfg_data;
            out_nxt.rx_clk  = 1'b1;
            out_nxt.tx_clk  = 1'b1;
         end
         RMS_ST_RX: begin
            // data moves just after bit start, so the rise lands mid-bit
            if (bit_start) begin
               out_nxt.rx_data = demod_bit;
            end
            out_nxt.rx_clk = !first_half;
            out_nxt.tx_clk = 1'b1;
         end
         RMS_ST_TX: begin
            // request edge at bit start, host has half a bit to react
            if (cfg.clk_rx_timing) begin
               out_nxt.rx_clk = first_half;
               out_nxt.tx_clk = 1'b1;
            end else begin
               out_nxt.rx_clk = 1'b1;
               out_nxt.tx_clk = first_half;
            end
         end
      endcase
      if (state_r != RMS_ST_OFF && state_r != RMS_ST_WAKE) begin
         // synchronised but unfiltered lock, so synthesizer glitches reach the pin
         out_nxt.lock = lock_s2_r;
         if (rssi_level > cfg.carrier_threshold_setting) begin
            out_nxt.carrier_present_out = 1'b0;
         end
      end
   end

   // payload to the modulator and setup traffic to the processor
   always_comb begin
      mod_bit_nxt    = mod_bit_r;
      mod_strobe_nxt = 1'b0;
      proc_rx_nxt    = 1'b1;
      radio_en_nxt   = (state_r != RMS_ST_OFF);
      ready_nxt      = (state_r == RMS_ST_SETUP) ||
                       (state_r == RMS_ST_RX) ||
                       (state_r == RMS_ST_TX);
      if (state_r == RMS_ST_TX && bit_mid) begin
         // sampled mid-bit, well after the host moved its data
         mod_bit_nxt    = pins_s2_r.tx_data;
         mod_strobe_nxt = 1'b1;
      end
      if (state_r == RMS_ST_SETUP) begin
         proc_rx_nxt = pins_s2_r.tx_data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         out_r        <= '{rx_data: 1'b0, rx_clk: 1'b0, tx_clk: 1'b0,
                           lock: 1'b0, carrier_present_out: 1'b1};
         mod_bit_r    <= 1'b0;
         mod_strobe_r <= 1'b0;
         proc_rx_r    <= 1'b1;
         radio_en_r   <= 1'b0;
         ready_r      <= 1'b0;
      end else begin
         out_r        <= out_nxt;
         mod_bit_r    <= mod_bit_nxt;
         mod_strobe_r <= mod_strobe_nxt;
         proc_rx_r    <= proc_rx_nxt;
         radio_en_r   <= radio_en_nxt;
         ready_r      <= ready_nxt;
      end
   end

   // every output straight from its flip-flop
   assign host_out       = out_r;
   assign mod_bit        = mod_bit_r;
   assign mod_bit_strobe = mod_strobe_r;
   assign proc_cfg_rx    = proc_rx_r;
   assign radio_enable   = radio_en_r;
   assign port_ready     = ready_r;

endmodule // rms_data_port

// ==== tb/rms_data_port_asserts.sv ====
// concurrent checks on the data port top-level ports
// assumes one core_clk domain with synchronous active-low rst_b
`timescale 1ns/10ps

module rms_data_port_asserts #(
   parameter int unsigned WAKE_CYC = 50
) (
   input wire logic                   core_clk,
   input wire logic                   rst_b,
   input wire rms_pkg::rms_pins_t     host_pins,
   input wire rms_pkg::rms_cfg_t      cfg,
   input wire logic                   synth_lock_raw,
   input wire logic [7:0]             rssi_level,
   input wire logic                   demod_bit,
   input wire logic                   proc_cfg_data,
   input wire rms_pkg::rms_host_out_t host_out,
   input wire logic                   mod_bit,
   input wire logic                   mod_bit_strobe,
   input wire logic                   proc_cfg_rx,
   input wire logic                   radio_enable,
   input wire logic                   port_ready
);
   import rms_pkg::*;
   // sync and register latency margin on top of the wake count
   localparam int WAKE_MAX = WAKE_CYC + 6;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   property p_shut;
      (!host_pins.shutdown_b) [*5] |-> !port_ready && !radio_enable
         && !host_out.lock && host_out.carrier_present_out;
   endproperty
   a_shut: assert property (p_shut)
      else $error("port active during shutdown");

   // cycles spent waiting for ready with shutdown released; a counter
   // because the real wake time is far past any delay range
   logic [31:0] wake_age;
   always_ff @(posedge core_clk) begin
      if (!rst_b || !host_pins.shutdown_b || port_ready) begin
         wake_age <= 32'h0;
      end else if (wake_age != 32'hffffffff) begin
         wake_age <= wake_age + 32'h1;
      end
   end

   // a new shutdown aborts the wake, so it disables the check
   property p_wake;
      @(posedge core_clk) disable iff (!rst_b || !host_pins.shutdown_b)
      $rose(host_pins.shutdown_b) |-> !port_ready [*8];
   endproperty
   a_wake: assert property (p_wake)
      else $error("port ready too early after wake");

   property p_wake_bound;
      wake_age <= 32'(WAKE_MAX);
   endproperty
   a_wake_bound: assert property (p_wake_bound)
      else $error("wake time out of bounds");

   property p_lock;
      (port_ready && $stable(synth_lock_raw)) [*5]
         |-> host_out.lock == synth_lock_raw;
   endproperty
   a_lock: assert property (p_lock)
      else $error("lock output disagrees with synthesizer");

   property p_carrier;
      port_ready [*2] |-> host_out.carrier_present_out ==
         !($past(rssi_level) > $past(cfg.carrier_threshold_setting));
   endproperty
   a_carrier: assert property (p_carrier)
      else $error("carrier output wrong for signal level");

   // six cycles cover pin sync and state latency of a mode change
   property p_rx_centre;
      (host_pins.shutdown_b && host_pins.setup_b && !host_pins.key_req) [*6]
         ##0 $rose(host_out.rx_clk) |=> $stable(host_out.rx_data) [*3];
   endproperty
   a_rx_centre: assert property (p_rx_centre)
      else $error("rx data moved near rx clock rise");

   property p_strobe_req;
      mod_bit_strobe |-> (cfg.clk_rx_timing ? $fell(host_out.rx_clk)
         : $fell(host_out.tx_clk)) ##1 !mod_bit_strobe;
   endproperty
   a_strobe_req: assert property (p_strobe_req)
      else $error("strobe not aligned to request clock");

   property p_txclk_gate;
      $fell(host_out.tx_clk) && port_ready
         |-> mod_bit_strobe && !cfg.clk_rx_timing;
   endproperty
   a_txclk_gate: assert property (p_txclk_gate)
      else $error("tx clock toggled when not selected");

   property p_mod_hold;
      !mod_bit_strobe |-> $stable(mod_bit);
   endproperty
   a_mod_hold: assert property (p_mod_hold)
      else $error("modulator bit changed without strobe");

   property p_setup;
      (!host_pins.setup_b && port_ready) [*5] |-> host_out.rx_clk
         && host_out.tx_clk && host_out.rx_data == $past(proc_cfg_data);
   endproperty
   a_setup: assert property (p_setup)
      else $error("setup mode outputs wrong");

   c_strobe: cover property (mod_bit_strobe);
   c_wake: cover property ($rose(port_ready));
   c_setup: cover property (!host_pins.setup_b && port_ready);
endmodule // rms_data_port_asserts

bind rms_data_port rms_data_port_asserts #(.WAKE_CYC(WAKE_CYC))
   u_rms_data_port_asserts (.core_clk(core_clk), .rst_b(rst_b),
   .host_pins(host_pins), .cfg(cfg), .synth_lock_raw(synth_lock_raw),
   .rssi_level(rssi_level), .demod_bit(demod_bit),
   .proc_cfg_data(proc_cfg_data), .host_out(host_out), .mod_bit(mod_bit),
   .mod_bit_strobe(mod_bit_strobe), .proc_cfg_rx(proc_cfg_rx),
   .radio_enable(radio_enable), .port_ready(port_ready));

// ==== tb/rms_host_model.sv ====
// host terminal model: feeds payload bits on request clock rises
// assumes req_clk is the bit clock picked for transmit timing
`timescale 1ns/10ps

module rms_host_model (
   input wire logic        core_clk,
   input wire logic        req_clk,
   input wire logic [15:0] pattern,
   output logic            tx_data,
   output logic [4:0]      sent
);
   logic req_q = 1'b1;

   initial begin
      tx_data = 1'b0;
      sent = 5'h00;
   end

   // next bit just after each rise, held until the next one
   always @(negedge core_clk) begin
      if (req_clk && !req_q) begin
         tx_data <= pattern[sent[3:0]];
         sent <= sent + 5'h01;
      end
      req_q <= req_clk;
   end
endmodule // rms_host_model

// ==== tb/rms_data_port_tb.sv ====
// self-checking bench for the modem data port
// assumes short sim counts: wake 50, bit periods 40..10 cycles
`timescale 1ns/10ps

module rms_data_port_tb;
   import rms_pkg::*;
   localparam int          WAKE = 50;
   localparam int          PER [5] = '{40, 32, 24, 16, 10};
   localparam logic [15:0] PAT = 16'hc35a;
   logic          core_clk = 1'b0;
   logic          rst_b = 1'b0;
   logic          sd_b, setup_b, key, lock_raw, demod, cfg_data;
   logic          mod_bit, strobe, cfg_rx, radio_en, ready, host_bit;
   logic [7:0]    rssi;
   logic [4:0]    sent;
   logic          tx_flip = 1'b0; // moves the data pin in setup mode
   rms_pins_t     pins;
   rms_cfg_t      cfg;
   rms_host_out_t hout;
   wire           req_clk = cfg.clk_rx_timing ? hout.rx_clk : hout.tx_clk;
   int            fail_count = 0;
   int            samples_checked = 0;
   int            cyc = 0;
   int            n, lo, hi;

   assign pins = {sd_b, setup_b, key, host_bit ^ tx_flip};

   rms_data_port #(.WAKE_CYC(WAKE), .BIT_CYC_4800(40), .BIT_CYC_8000(32),
      .BIT_CYC_9600(24), .BIT_CYC_16000(16), .BIT_CYC_19200(10))
      u_rms_data_port (.core_clk(core_clk), .rst_b(rst_b),
      .host_pins(pins), .cfg(cfg), .synth_lock_raw(lock_raw),
      .rssi_level(rssi), .demod_bit(demod), .proc_cfg_data(cfg_data),
      .host_out(hout), .mod_bit(mod_bit), .mod_bit_strobe(strobe),
      .proc_cfg_rx(cfg_rx), .radio_enable(radio_en), .port_ready(ready));

   rms_host_model u_rms_host_model (.core_clk(core_clk),
      .req_clk(req_clk), .pattern(PAT), .tx_data(host_bit), .sent(sent));

   always #5 core_clk = ~core_clk;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(negedge core_clk);
   endtask

   // bounded wait for a level on the request clock, cycles counted
   task automatic wait_lvl(input logic v, output int k);
      k = 0;
      while (req_clk !== v && k < 200) begin
         tick(1);
         k++;
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // hang guard, far above the expected run length
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end

   initial begin
      {sd_b, setup_b, key, lock_raw, demod, cfg_data} = 6'h30;
      rssi = 8'h00;
      cfg = '{3'h4, 1'b1, 8'h40};
      tick(4);
      check(16'({ready, radio_en, hout}), 16'h0001);
      rst_b = 1'b1;
      tick(70);
      sd_b = 1'b0;
      tick(8);
      check(16'({ready, radio_en, hout}), 16'h0001);
      sd_b = 1'b1;
      n = 0;
      while (!ready && n < 100) begin
         tick(1);
         n++;
      end
      check(16'(n >= WAKE && n <= WAKE + 6), 16'h0001);
      check(16'(radio_en), 16'h0001);
      $display("wake test done");
      // periods grow so a rate change never wraps the timer
      for (int s = 4; s >= 0; s--) begin
         cfg.rate_sel = 3'(s);
         demod = s[0];
         tick(3 * PER[s]);
         wait_lvl(1'b0, n);
         wait_lvl(1'b1, n);
         check(16'(hout.rx_data), 16'(s[0]));
         check(16'(hout.tx_clk), 16'h0001);
         wait_lvl(1'b0, hi);
         wait_lvl(1'b1, lo);
         check(16'(hi), 16'(PER[s] / 2));
         check(16'(lo), 16'(PER[s] / 2));
      end
      $display("receive test done");
      for (int i = 0; i < 3; i++) begin
         rssi = 8'h3f + 8'(i);
         lock_raw = i[0];
         tick(6);
         check(16'({hout.lock, hout.carrier_present_out}),
            16'({i[0], i != 2}));
      end
      $display("indicator test done");
      for (int t = 0; t < 2; t++) begin
         cfg.clk_rx_timing = t[0];
         key = 1'b1;
         tick(20);
         repeat (8) begin
            n = 0;
            while (!strobe && n < 60) begin
               tick(1);
               n++;
            end
            check(16'(mod_bit), 16'(PAT[sent[3:0] - 4'h1]));
            check(16'(t[0] ? hout.tx_clk : hout.rx_clk), 16'h0001);
            tick(1);
         end
         key = 1'b0;
         tick(20);
      end
      $display("transmit test done");
      setup_b = 1'b0;
      tick(10);
      for (int i = 0; i < 4; i++) begin
         cfg_data = i[0];
         tx_flip = i[1];
         tick(4);
         check(16'({hout.rx_clk, hout.tx_clk}), 16'h0003);
         check(16'({hout.rx_data, cfg_rx}),
            16'({i[0], host_bit ^ tx_flip}));
      end
      $display("setup test done");
      tally_and_finish();
   end
endmodule // rms_data_port_tb
